// ---- verilog/cmoi_ctrl.v ----
// Message object store and interrupt controller of a CAN node with an AHB-Lite register slave.
//
// Implementation choices: register access over AHB-Lite and the register addresses.
`include "cmoi_regs.vh"
module cmoi_ctrl (
	input wire clk,
	input wire rstn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg hreadyout,
	output reg [31:0] hrdata,
	output reg hresp,
	output reg irq,
	input wire rx_valid,
	input wire [28:0] rx_id,
	input wire rx_ext,
	input wire rx_remote,
	input wire [3:0] rx_dlc,
	input wire [63:0] rx_data,
	input wire tx_done,
	input wire [7:0] tx_err_cnt,
	input wire [7:0] rx_err_cnt,
	input wire bus_off,
	input wire lec_valid,
	input wire [2:0] lec_code,
	output reg tx_req,
	output reg [4:0] tx_obj,
	output reg [28:0] tx_id,
	output reg tx_ext,
	output reg tx_remote,
	output reg [3:0] tx_dlc,
	output reg [63:0] tx_data,
	output reg ctrl_enable
);

	reg ph_wr_reg;
	reg ph_rd_reg;
	reg [7:0] addr_reg;
	reg ie_master_reg;
	reg ie_error_reg;
	reg ie_status_reg;
	reg stat_pend_reg;
	reg err_pend_reg;
	reg txok_reg;
	reg rxok_reg;
	reg [2:0] lec_reg;
	reg ewarn_prev_reg;
	reg epass_prev_reg;
	reg boff_prev_reg;
	reg [28:0] if_id_reg;
	reg [28:0] if_mask_reg;
	reg [13:0] if_cfg_reg;
	reg [63:0] if_data_reg;
	reg [31:0] obj_valid_reg;
	reg [31:0] new_data_flag;
	reg [31:0] data_lost_flag;
	reg [31:0] object_pending_mask;
	reg [31:0] txrq_reg;
	reg [28:0] id_mem [0:31];
	reg [28:0] mask_mem [0:31];
	reg [2:0] role_mem [0:31];
	reg [31:0] ext_mem;
	reg [31:0] txie_mem;
	reg [31:0] rxie_mem;
	reg [31:0] filt_mem;
	reg [3:0] dlc_mem [0:31];
	reg [63:0] data_mem [0:31];
	wire [31:0] valid_next;
	wire [31:0] newdat_next;
	wire [31:0] lost_next;
	wire [31:0] pend_next;
	wire [31:0] txrq_next;
	wire [31:0] match;
	wire [31:0] tx_able;
	reg win_valid;
	reg [4:0] win_idx;
	reg pend_any;
	reg [4:0] pend_idx;
	reg txc_valid;
	reg [4:0] txc_idx;
	reg [31:0] irq_cause_reg;
	reg [31:0] rd_data;
	integer k;

	// Address phase is taken only while the bus is ready; reads get one wait state so read data leaves a flop.
	wire ahb_take = hsel && htrans[1] && hready;
	wire cmd_wr = ph_wr_reg && (addr_reg == `CMOI_OFS_CMD);
	wire [5:0] cmd_num = hwdata[5:0];
	wire [5:0] cmd_num_m1 = cmd_num - 6'h01;
	wire cmd_ok = cmd_wr && (cmd_num != 6'h00) && (cmd_num <= `CMOI_NUM_OBJ);
	wire [4:0] cidx = cmd_num_m1[4:0];
	wire do_cfg = cmd_ok && hwdata[`CMOI_CMD_WRITE];
	wire do_read = cmd_ok && hwdata[`CMOI_CMD_READ];
	wire do_clrint = cmd_ok && hwdata[`CMOI_CMD_CLRINT];
	wire do_inval = cmd_ok && hwdata[`CMOI_CMD_INVAL];
	wire do_txreq = cmd_ok && hwdata[`CMOI_CMD_TXREQ];
	wire do_rdclr = cmd_ok && hwdata[`CMOI_CMD_RDCLR];
	wire status_rd = ph_rd_reg && (addr_reg == `CMOI_OFS_STATUS);
	wire rx_take = rx_valid && ctrl_enable;
	wire store = rx_take && win_valid;
	wire txd = tx_done && tx_req;

	// Error levels derived from the counters; warning at 96, passive at 128.
	wire ewarn = (tx_err_cnt >= `CMOI_WARN_LIMIT) || (rx_err_cnt >= `CMOI_WARN_LIMIT);
	wire epass = (tx_err_cnt >= `CMOI_PASSIVE_LIMIT) || (rx_err_cnt >= `CMOI_PASSIVE_LIMIT);
	wire err_event = (ewarn && !ewarn_prev_reg) || (epass && !epass_prev_reg) || (bus_off && !boff_prev_reg);
	wire stat_event = rx_take || txd || (lec_valid && (lec_code != 3'h0));

	// Bus handshake state.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ph_wr_reg <= 1'b0;
			ph_rd_reg <= 1'b0;
			addr_reg <= 8'h00;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h0000_0000;
		end else begin
			ph_wr_reg <= ahb_take && hwrite;
			ph_rd_reg <= ahb_take && !hwrite;
			hreadyout <= !(ahb_take && !hwrite);
			hresp <= 1'b0;
			if (ahb_take) begin
				addr_reg <= haddr[7:0];
			end
			if (ph_rd_reg) begin
				hrdata <= rd_data;
			end
		end
	end

	// Control, status and interrupt state; a new event wins over the clearing read of the same cycle.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_enable <= 1'b0;
			ie_master_reg <= 1'b0;
			ie_error_reg <= 1'b0;
			ie_status_reg <= 1'b0;
			stat_pend_reg <= 1'b0;
			err_pend_reg <= 1'b0;
			txok_reg <= 1'b0;
			rxok_reg <= 1'b0;
			lec_reg <= 3'h0;
			ewarn_prev_reg <= 1'b0;
			epass_prev_reg <= 1'b0;
			boff_prev_reg <= 1'b0;
			irq <= 1'b0;
		end else begin
			if (ph_wr_reg && (addr_reg == `CMOI_OFS_CTRL)) begin
				ctrl_enable <= hwdata[`CMOI_CTRL_ENABLE];
				ie_master_reg <= hwdata[`CMOI_CTRL_IE_MASTER];
				ie_error_reg <= hwdata[`CMOI_CTRL_IE_ERROR];
				ie_status_reg <= hwdata[`CMOI_CTRL_IE_STATUS];
			end
			ewarn_prev_reg <= ewarn;
			epass_prev_reg <= epass;
			boff_prev_reg <= bus_off;
			if (err_event) begin
				err_pend_reg <= 1'b1;
			end else if (status_rd) begin
				err_pend_reg <= 1'b0;
			end
			if (stat_event) begin
				stat_pend_reg <= 1'b1;
			end else if (status_rd) begin
				stat_pend_reg <= 1'b0;
			end
			if (rx_take) begin
				rxok_reg <= 1'b1;
			end else if (status_rd) begin
				rxok_reg <= 1'b0;
			end
			if (txd) begin
				txok_reg <= 1'b1;
			end else if (status_rd) begin
				txok_reg <= 1'b0;
			end
			if (lec_valid) begin
				lec_reg <= lec_code;
			end
			// Error and status are each gated by their own enable, object pending bits only by the master enable.
			irq <= ie_master_reg && ((ie_error_reg && err_pend_reg) || (ie_status_reg && stat_pend_reg) ||
				(|object_pending_mask));
		end
	end

	// Per-object acceptance and flag updates.
	genvar gi;
	generate
		for (gi = 0; gi < 32; gi = gi + 1) begin : g_obj
			wire sel = cmd_ok && (cidx == gi);
			wire wipe = sel && (hwdata[`CMOI_CMD_WRITE] || hwdata[`CMOI_CMD_INVAL]);
			wire [28:0] fmt = ext_mem[gi] ? `CMOI_ID_EXT_MASK : `CMOI_ID_STD_MASK;
			wire [28:0] cmp = filt_mem[gi] ? (mask_mem[gi] & fmt) : fmt;
			wire id_hit = ((rx_id & cmp) == (id_mem[gi] & cmp)) && (ext_mem[gi] == rx_ext);
			wire role_rx = rx_remote ? ((role_mem[gi] == `CMOI_ROLE_REQ_RX) || (role_mem[gi] == `CMOI_ROLE_AUTOREPLY)) :
				((role_mem[gi] == `CMOI_ROLE_DATA_RX) || (role_mem[gi] == `CMOI_ROLE_REQ_TX));
			wire hit = store && (win_idx == gi);
			wire sent = txd && (tx_obj == gi);
			assign match[gi] = obj_valid_reg[gi] && id_hit && role_rx;
			assign tx_able[gi] = obj_valid_reg[gi] && txrq_reg[gi];
			assign valid_next[gi] = do_inval && sel ? 1'b0 : (do_cfg && sel ? 1'b1 : obj_valid_reg[gi]);
			assign newdat_next[gi] = wipe ? 1'b0 : (hit ? 1'b1 : ((do_read && sel) ? 1'b0 : new_data_flag[gi]));
			assign lost_next[gi] = wipe ? 1'b0 : ((hit && new_data_flag[gi]) ? 1'b1 :
				((do_read && sel) ? 1'b0 : data_lost_flag[gi]));
			assign pend_next[gi] = wipe ? 1'b0 : (((hit && rxie_mem[gi]) || (sent && txie_mem[gi])) ? 1'b1 :
				(((do_clrint || (do_read && do_rdclr)) && sel) ? 1'b0 : object_pending_mask[gi]));
			assign txrq_next[gi] = wipe ? 1'b0 : (((hit && (role_mem[gi] == `CMOI_ROLE_AUTOREPLY)) ||
				(do_txreq && sel)) ? 1'b1 : (sent ? 1'b0 : txrq_reg[gi]));
		end
	endgenerate

	// Object flags hold defined values from reset even though the frame storage does not.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			obj_valid_reg <= 32'h0000_0000;
			new_data_flag <= 32'h0000_0000;
			data_lost_flag <= 32'h0000_0000;
			object_pending_mask <= 32'h0000_0000;
			txrq_reg <= 32'h0000_0000;
		end else begin
			obj_valid_reg <= valid_next;
			new_data_flag <= newdat_next;
			data_lost_flag <= lost_next;
			object_pending_mask <= pend_next;
			txrq_reg <= txrq_next;
		end
	end

	// Lowest-numbered winners for reception, interrupt cause and transmission.
	always @* begin
		win_valid = 1'b0;
		win_idx = 5'h00;
		pend_any = 1'b0;
		pend_idx = 5'h00;
		txc_valid = 1'b0;
		txc_idx = 5'h00;
		for (k = 31; k >= 0; k = k - 1) begin
			if (match[k]) begin
				win_valid = 1'b1;
				win_idx = k[4:0];
			end
			if (object_pending_mask[k]) begin
				pend_any = 1'b1;
				pend_idx = k[4:0];
			end
			if (tx_able[k]) begin
				txc_valid = 1'b1;
				txc_idx = k[4:0];
			end
		end
	end

	// Cause: status code first, then object number, zero when idle.
	always @* begin
		if (stat_pend_reg || err_pend_reg) begin
			irq_cause_reg = `CMOI_STATUS_CODE;
		end else if (pend_any) begin
			irq_cause_reg = {27'h000_0000, pend_idx} + 32'h0000_0001;
		end else begin
			irq_cause_reg = 32'h0000_0000;
		end
	end

	// Object storage; it is not reset, so software must configure objects before enabling.
	always @(posedge clk) begin
		if (do_cfg) begin
			id_mem[cidx] <= if_id_reg;
			mask_mem[cidx] <= if_mask_reg;
			role_mem[cidx] <= if_cfg_reg[2:0];
			ext_mem[cidx] <= if_cfg_reg[`CMOI_CFG_EXT];
			txie_mem[cidx] <= if_cfg_reg[`CMOI_CFG_TXIE];
			rxie_mem[cidx] <= if_cfg_reg[`CMOI_CFG_RXIE];
			filt_mem[cidx] <= if_cfg_reg[`CMOI_CFG_FILT];
			dlc_mem[cidx] <= if_cfg_reg[11:8];
			data_mem[cidx] <= if_data_reg;
		end
		// A remote frame carries no payload, so only data frames overwrite the buffer.
		if (store && !rx_remote && !(do_cfg && (cidx == win_idx))) begin
			dlc_mem[win_idx] <= rx_dlc;
			data_mem[win_idx] <= rx_data;
		end
	end

	// Transfer window registers, loaded by host writes or by an object read command.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			if_id_reg <= 29'h0000_0000;
			if_mask_reg <= 29'h0000_0000;
			if_cfg_reg <= 14'h0000;
			if_data_reg <= 64'h0000_0000_0000_0000;
		end else if (do_read) begin
			if_id_reg <= id_mem[cidx];
			if_mask_reg <= mask_mem[cidx];
			if_cfg_reg <= {data_lost_flag[cidx], new_data_flag[cidx], dlc_mem[cidx], 1'b0, filt_mem[cidx],
				rxie_mem[cidx], txie_mem[cidx], ext_mem[cidx], role_mem[cidx]};
			if_data_reg <= data_mem[cidx];
		end else if (ph_wr_reg) begin
			case (addr_reg)
				`CMOI_OFS_ID: begin
					if_id_reg <= hwdata[28:0];
				end
				`CMOI_OFS_MASK: begin
					if_mask_reg <= hwdata[28:0];
				end
				`CMOI_OFS_CFG: begin
					if_cfg_reg <= {2'h0, hwdata[11:8], 1'b0, hwdata[6:0]};
				end
				`CMOI_OFS_DATA0: begin
					if_data_reg[31:0] <= hwdata;
				end
				`CMOI_OFS_DATA1: begin
					if_data_reg[63:32] <= hwdata;
				end
				default: begin
					if_id_reg <= if_id_reg;
				end
			endcase
		end
	end

	// Transmit request toward the bit engine; held until done, the object loses its request or the controller is disabled.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tx_req <= 1'b0;
			tx_obj <= 5'h00;
			tx_id <= 29'h0000_0000;
			tx_ext <= 1'b0;
			tx_remote <= 1'b0;
			tx_dlc <= 4'h0;
			tx_data <= 64'h0000_0000_0000_0000;
		end else if (tx_req) begin
			if (txd || !tx_able[tx_obj] || !ctrl_enable) begin
				tx_req <= 1'b0;
			end
		end else if (txc_valid && ctrl_enable && !txd) begin
			tx_req <= 1'b1;
			tx_obj <= txc_idx;
			tx_id <= id_mem[txc_idx];
			tx_ext <= ext_mem[txc_idx];
			tx_remote <= (role_mem[txc_idx] == `CMOI_ROLE_REQ_TX);
			tx_dlc <= dlc_mem[txc_idx];
			tx_data <= data_mem[txc_idx];
		end
	end

	// Read multiplexer; unmapped offsets read zero.
	always @* begin
		case (addr_reg)
			`CMOI_OFS_CTRL: rd_data = {28'h000_0000, ie_status_reg, ie_error_reg, ie_master_reg, ctrl_enable};
			`CMOI_OFS_STATUS: rd_data = {24'h00_0000, bus_off, ewarn, epass, rxok_reg, txok_reg, lec_reg};
			`CMOI_OFS_CAUSE: rd_data = irq_cause_reg;
			`CMOI_OFS_PEND: rd_data = object_pending_mask;
			`CMOI_OFS_NEWDAT: rd_data = new_data_flag;
			`CMOI_OFS_VALID: rd_data = obj_valid_reg;
			`CMOI_OFS_TXRQ: rd_data = txrq_reg;
			`CMOI_OFS_ID: rd_data = {3'h0, if_id_reg};
			`CMOI_OFS_MASK: rd_data = {3'h0, if_mask_reg};
			`CMOI_OFS_CFG: rd_data = {18'h0_0000, if_cfg_reg};
			`CMOI_OFS_DATA0: rd_data = if_data_reg[31:0];
			`CMOI_OFS_DATA1: rd_data = if_data_reg[63:32];
			default: rd_data = 32'h0000_0000;
		endcase
	end

endmodule // cmoi_ctrl

// ---- verilog/cmoi_regs.vh ----
// Register offsets, field positions and limits of the message object and interrupt controller.
`ifndef CMOI_REGS_VH
`define CMOI_REGS_VH
`define CMOI_OFS_CTRL 8'h00
`define CMOI_OFS_STATUS 8'h04
`define CMOI_OFS_CAUSE 8'h08
`define CMOI_OFS_PEND 8'h0c
`define CMOI_OFS_NEWDAT 8'h10
`define CMOI_OFS_VALID 8'h14
`define CMOI_OFS_TXRQ 8'h18
`define CMOI_OFS_CMD 8'h20
`define CMOI_OFS_ID 8'h24
`define CMOI_OFS_MASK 8'h28
`define CMOI_OFS_CFG 8'h2c
`define CMOI_OFS_DATA0 8'h30
`define CMOI_OFS_DATA1 8'h34
`define CMOI_CTRL_ENABLE 0
`define CMOI_CTRL_IE_MASTER 1
`define CMOI_CTRL_IE_ERROR 2
`define CMOI_CTRL_IE_STATUS 3
`define CMOI_CMD_WRITE 8
`define CMOI_CMD_READ 9
`define CMOI_CMD_CLRINT 10
`define CMOI_CMD_INVAL 11
`define CMOI_CMD_TXREQ 12
`define CMOI_CMD_RDCLR 13
`define CMOI_CFG_EXT 3
`define CMOI_CFG_TXIE 4
`define CMOI_CFG_RXIE 5
`define CMOI_CFG_FILT 6
`define CMOI_ROLE_DATA_TX 3'h0
`define CMOI_ROLE_REQ_TX 3'h1
`define CMOI_ROLE_DATA_RX 3'h2
`define CMOI_ROLE_REQ_RX 3'h3
`define CMOI_ROLE_AUTOREPLY 3'h4
`define CMOI_STATUS_CODE 32'h0000_8000
`define CMOI_WARN_LIMIT 8'h60
`define CMOI_PASSIVE_LIMIT 8'h80
`define CMOI_NUM_OBJ 6'h20
`define CMOI_ID_EXT_MASK 29'h1fff_ffff
`define CMOI_ID_STD_MASK 29'h0000_07ff
`endif

// ---- sim/cmoi_ctrl_assertions.sv ----
// Concurrent checks on the ports of the message object and interrupt controller.
`include "cmoi_regs.vh"
module cmoi_ctrl_assertions (
	input wire clk,
	input wire rstn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [31:0] hwdata,
	input wire hready,
	input wire hreadyout,
	input wire hresp,
	input wire irq,
	input wire rx_valid,
	input wire tx_req,
	input wire tx_done,
	input wire [4:0] tx_obj,
	input wire ctrl_enable
);
	reg ctrl_wr_reg;
	reg [1:0] ctrl_reg;
	wire take = hsel & htrans[1] & hready;
	// Shadow of the controller and master enable bits, rebuilt from bus writes so the checker needs no internal probes.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_wr_reg <= 1'b0;
			ctrl_reg <= 2'h0;
		end else begin
			ctrl_wr_reg <= take & hwrite & (haddr[7:0] == `CMOI_OFS_CTRL);
			if (ctrl_wr_reg) begin
				ctrl_reg <= hwdata[1:0];
			end
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	a_read_one_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read data phase does not take exactly one wait state");
	a_write_no_wait: assert property (take && hwrite |=> hreadyout)
		else $error("write data phase was stretched");
	a_resp_always_okay: assert property (!hresp)
		else $error("slave response is not okay");
	a_master_gates_irq: assert property (!ctrl_reg[1] [*3] |-> !irq)
		else $error("interrupt raised with master enable clear");
	a_enable_follows_on: assert property (ctrl_reg[0] [*2] |-> ctrl_enable)
		else $error("controller enable does not follow control write");
	a_enable_follows_off: assert property (!ctrl_reg[0] [*2] |-> !ctrl_enable)
		else $error("controller enabled without a control write");
	a_tx_drop_done: assert property (tx_req && tx_done |=> !tx_req)
		else $error("transmit offer held after completion");
	a_tx_obj_stable: assert property (tx_req && $past(tx_req) |-> $stable(tx_obj))
		else $error("offered object changed during an offer");
	a_tx_needs_enable: assert property ($rose(tx_req) |-> $past(ctrl_enable))
		else $error("transmit offered while controller disabled");
	c_rx_frame: cover property (rx_valid);
	c_tx_done: cover property (tx_req && tx_done);
	c_irq_rise: cover property ($rose(irq));
endmodule // cmoi_ctrl_assertions

bind cmoi_ctrl cmoi_ctrl_assertions chk_u (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
	.rx_valid(rx_valid), .tx_req(tx_req), .tx_done(tx_done), .tx_obj(tx_obj), .ctrl_enable(ctrl_enable));

// ---- sim/cmoi_core_model.sv ----
// Behavioural CAN core on the far side of the controller: delivers frames and completes offers.
module cmoi_core_model (
	input wire clk,
	input wire tx_req,
	input wire [4:0] tx_obj,
	input wire tx_remote,
	input wire [63:0] tx_data,
	output logic tx_done,
	output logic rx_valid,
	output logic [28:0] rx_id,
	output logic rx_ext,
	output logic rx_remote,
	output logic [3:0] rx_dlc,
	output logic [63:0] rx_data,
	output logic [7:0] tx_err_cnt
);
	timeunit 1ns;
	timeprecision 1ns;
	int delay = 1;
	int wait_cnt = 0;
	int tx_cnt = 0;
	logic [63:0] got_data [32];
	logic got_rem [32];
	// Quiet lines at time zero.
	initial begin
		{tx_done, rx_valid, rx_ext, rx_remote} = 4'h0;
		rx_id = 29'h0000_0000;
		rx_dlc = 4'h0;
		rx_data = 64'h0000_0000_0000_0000;
		tx_err_cnt = 8'h00;
	end
	// Completes an offer after a chosen delay; a slow bus makes the controller hold its offer.
	always @(posedge clk) begin
		tx_done <= 1'b0;
		if (tx_req && !tx_done) begin
			if (wait_cnt >= delay) begin
				tx_done <= 1'b1;
				wait_cnt <= 0;
				tx_cnt <= tx_cnt + 1;
				got_data[tx_obj] <= tx_data;
				got_rem[tx_obj] <= tx_remote;
			end else begin
				wait_cnt <= wait_cnt + 1;
			end
		end
	end
	// One frame for one cycle; afterwards the lines carry junk so no stale value can be trusted.
	task send(input [28:0] id, input ext, input rem, input [63:0] d);
		@(posedge clk);
		rx_valid <= 1'b1;
		{rx_id, rx_ext, rx_remote, rx_dlc, rx_data} <= {id, ext, rem, 4'h8, d};
		@(posedge clk);
		rx_valid <= 1'b0;
		{rx_id, rx_ext, rx_remote, rx_dlc, rx_data} <= ~{id, ext, rem, 4'h8, d};
	endtask
endmodule // cmoi_core_model

// ---- sim/tb_can_message_object_interrupts.sv ----
// Self-checking bench of the message object and interrupt controller.
`include "cmoi_regs.vh"
module tb_can_message_object_interrupts;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0;
	logic rstn = 0;
	logic hsel = 0;
	logic hwrite = 0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] rv;
	int bad_count = 0;
	int checks_done = 0;
	wire hreadyout, hresp, irq, rx_valid, rx_ext, rx_remote, tx_done, tx_req, tx_remote, ctrl_enable;
	wire [31:0] hrdata;
	wire [28:0] rx_id;
	wire [3:0] rx_dlc;
	wire [63:0] rx_data, tx_data;
	wire [7:0] tx_err_cnt;
	wire [28:0] tx_id;
	wire [3:0] tx_dlc;
	wire tx_ext;
	// Error inputs of the controller, driven by the bench so the error and status paths are exercised.
	logic [7:0] rx_err_cnt = 8'h00;
	logic bus_off = 1'b0;
	logic lec_valid = 1'b0;
	logic [2:0] lec_code = 3'h0;
	wire [4:0] tx_obj;
	// Clock at 25 MHz.
	always #20 clk = ~clk;
	// The controller; as the only slave its ready is the bus ready.
	cmoi_ctrl dut_u (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.irq(irq), .rx_valid(rx_valid), .rx_id(rx_id), .rx_ext(rx_ext), .rx_remote(rx_remote), .rx_dlc(rx_dlc),
		.rx_data(rx_data), .tx_done(tx_done), .tx_err_cnt(tx_err_cnt), .rx_err_cnt(rx_err_cnt), .bus_off(bus_off),
		.lec_valid(lec_valid), .lec_code(lec_code), .tx_req(tx_req), .tx_obj(tx_obj), .tx_id(tx_id), .tx_ext(tx_ext),
		.tx_remote(tx_remote), .tx_dlc(tx_dlc), .tx_data(tx_data), .ctrl_enable(ctrl_enable));
	cmoi_core_model core_u (.clk(clk), .tx_req(tx_req), .tx_obj(tx_obj), .tx_remote(tx_remote),
		.tx_data(tx_data), .tx_done(tx_done), .rx_valid(rx_valid), .rx_id(rx_id), .rx_ext(rx_ext),
		.rx_remote(rx_remote), .rx_dlc(rx_dlc), .rx_data(rx_data), .tx_err_cnt(tx_err_cnt));
	task stop_test;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Waits for ready at a rising edge; a hung slave ends the run.
	task wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1) begin
			bad_count++;
			stop_test;
		end
	endtask
	// One single word transfer, entered just after a rising edge.
	task xfer(input logic w, input [7:0] a, input [31:0] d, output [31:0] q);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		wait_rdy;
		{hsel, htrans} <= 3'h0;
		hwdata <= d;
		wait_rdy;
		q = hrdata;
	endtask
	task wr(input [7:0] a, input [31:0] d);
		xfer(1'b1, a, d, rv);
	endtask
	task rchk(input [7:0] a, input [31:0] e);
		xfer(1'b0, a, 32'h0000_0000, rv);
		chk($sformatf("reg %h", a), 64'(rv), 64'(e));
	endtask
	task cmd(input [5:0] n, input int b);
		wr(`CMOI_OFS_CMD, (32'h0000_0001 << b) | 32'(n));
	endtask
	// Fills the window and commits it; the old definition of the object is replaced.
	task obj(input [5:0] n, input [28:0] id, input [28:0] mask, input [31:0] cfg, input [63:0] d);
		wr(`CMOI_OFS_ID, 32'(id));
		wr(`CMOI_OFS_MASK, 32'(mask));
		wr(`CMOI_OFS_CFG, cfg);
		wr(`CMOI_OFS_DATA0, d[31:0]);
		wr(`CMOI_OFS_DATA1, d[63:32]);
		cmd(n, `CMOI_CMD_WRITE);
	endtask
	task wait_tx(input int n);
		int k;
		k = 0;
		while (core_u.tx_cnt < n && k < 100) begin
			@(posedge clk);
			k++;
		end
		if (core_u.tx_cnt < n) begin
			bad_count++;
			stop_test;
		end
	endtask
	// Main sequence: reset, receive with filter, transmit, clears, gating, roles and errors.
	initial begin
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		chk("ctrl_enable", 64'(ctrl_enable), 64'h0);
		rchk(`CMOI_OFS_CAUSE, 32'h0000_0000);
		rchk(`CMOI_OFS_VALID, 32'h0000_0000);
		rchk(8'h1c, 32'h0000_0000);
		obj(5, 29'h120, 29'h7f0, 32'h0000_0862, 64'h0);
		obj(3, 29'h301, 29'h0, 32'h0000_0810, 64'h8877_6655_4433_2211);
		obj(9, 29'h302, 29'h0, 32'h0000_0800, 64'h0);
		wr(`CMOI_OFS_CTRL, 32'h0000_000b);
		rchk(`CMOI_OFS_VALID, 32'h0000_0114);
		core_u.send(29'h22a, 1'b0, 1'b0, 64'h0);
		rchk(`CMOI_OFS_NEWDAT, 32'h0000_0000);
		core_u.send(29'h12a, 1'b0, 1'b0, 64'h1111_2222_3333_4444);
		rchk(`CMOI_OFS_NEWDAT, 32'h0000_0010);
		rchk(`CMOI_OFS_PEND, 32'h0000_0010);
		chk("irq", 64'(irq), 64'h1);
		rchk(`CMOI_OFS_CAUSE, `CMOI_STATUS_CODE);
		rchk(`CMOI_OFS_STATUS, 32'h0000_0010);
		rchk(`CMOI_OFS_CAUSE, 32'h0000_0005);
		core_u.send(29'h125, 1'b0, 1'b0, 64'h5555_6666_7777_8888);
		core_u.delay = 5;
		cmd(9, `CMOI_CMD_TXREQ);
		cmd(3, `CMOI_CMD_TXREQ);
		wait_tx(2);
		core_u.delay = 0;
		chk("tx data", core_u.got_data[2], 64'h8877_6655_4433_2211);
		rchk(`CMOI_OFS_TXRQ, 32'h0000_0000);
		rchk(`CMOI_OFS_PEND, 32'h0000_0014);
		rchk(`CMOI_OFS_STATUS, 32'h0000_0018);
		rchk(`CMOI_OFS_CAUSE, 32'h0000_0003);
		cmd(3, `CMOI_CMD_CLRINT);
		rchk(`CMOI_OFS_CAUSE, 32'h0000_0005);
		wr(`CMOI_OFS_CTRL, 32'h0000_0009);
		rchk(`CMOI_OFS_PEND, 32'h0000_0010);
		chk("irq", 64'(irq), 64'h0);
		wr(`CMOI_OFS_CTRL, 32'h0000_000b);
		rchk(`CMOI_OFS_PEND, 32'h0000_0010);
		chk("irq", 64'(irq), 64'h1);
		wr(`CMOI_OFS_CMD, 32'h0000_2205);
		rchk(`CMOI_OFS_CFG, 32'h0000_3862);
		rchk(`CMOI_OFS_DATA0, 32'h7777_8888);
		rchk(`CMOI_OFS_DATA1, 32'h5555_6666);
		rchk(`CMOI_OFS_PEND, 32'h0000_0000);
		rchk(`CMOI_OFS_NEWDAT, 32'h0000_0000);
		cmd(5, `CMOI_CMD_INVAL);
		core_u.send(29'h120, 1'b0, 1'b0, 64'h0);
		rchk(`CMOI_OFS_NEWDAT, 32'h0000_0000);
		rchk(`CMOI_OFS_VALID, 32'h0000_0104);
		obj(9, 29'h302, 29'h0, 32'h0000_0822, 64'h0);
		obj(12, 29'h1abc_def, 29'h0, 32'h0000_080c, 64'h0000_0000_0000_beef);
		obj(13, 29'h333, 29'h0, 32'h0000_0821, 64'h0);
		core_u.send(29'h302, 1'b0, 1'b0, 64'h0);
		core_u.send(29'h1abc_def, 1'b1, 1'b1, 64'h0);
		wait_tx(3);
		chk("reply data", core_u.got_data[11], 64'h0000_0000_0000_beef);
		chk("reply kind", 64'(core_u.got_rem[11]), 64'h0);
		chk("reply id", 64'(tx_id), 64'h1abc_def);
		chk("reply format", 64'(tx_ext), 64'h1);
		chk("reply length", 64'(tx_dlc), 64'h8);
		cmd(13, `CMOI_CMD_TXREQ);
		wait_tx(4);
		chk("request kind", 64'(core_u.got_rem[12]), 64'h1);
		chk("request id", 64'(tx_id), 64'h333);
		core_u.send(29'h333, 1'b0, 1'b0, 64'h0000_0000_0000_cafe);
		rchk(`CMOI_OFS_PEND, 32'h0000_1100);
		rchk(`CMOI_OFS_STATUS, 32'h0000_0018);
		wr(`CMOI_OFS_CTRL, 32'h0000_0007);
		core_u.tx_err_cnt <= 8'h60;
		rchk(`CMOI_OFS_CAUSE, `CMOI_STATUS_CODE);
		chk("irq", 64'(irq), 64'h1);
		rchk(`CMOI_OFS_STATUS, 32'h0000_0040);
		rchk(`CMOI_OFS_CAUSE, 32'h0000_0009);
		// A bus error code for one cycle raises the status cause and is kept in the status word.
		lec_valid <= 1'b1;
		lec_code <= 3'h3;
		@(posedge clk);
		lec_valid <= 1'b0;
		rchk(`CMOI_OFS_CAUSE, `CMOI_STATUS_CODE);
		rchk(`CMOI_OFS_STATUS, 32'h0000_0043);
		rchk(`CMOI_OFS_CAUSE, 32'h0000_0009);
		// Entering bus-off raises the error cause; the passive level shows once a counter reaches it.
		bus_off <= 1'b1;
		rx_err_cnt <= 8'h80;
		rchk(`CMOI_OFS_CAUSE, `CMOI_STATUS_CODE);
		rchk(`CMOI_OFS_STATUS, 32'h0000_00e3);
		rchk(`CMOI_OFS_CAUSE, 32'h0000_0009);
		stop_test;
	end
endmodule // tb_can_message_object_interrupts
